// *** rtl/sbs_port.sv ***
// Synchronous pipelined burst SRAM port with 2-bit burst counter
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Starting address captured whole and a 2-bit beat counter cleared to zero, which then advances on the step input.
// - All synchronous pins are registered on the rising clock edge.
// - Burst order pin high selects interleaved order, low selects linear.
// - The controller address strobe, or the processor strobe while the first chip select is low, starts a burst.
// - Address and chip selects load only at edges where a strobe is active.
// - Later burst addresses are generated inside; step input decides each step.
// - Output enable and sleep act without waiting for a clock edge.
// - Four-beat burst completes 3-1-1-1: three clocks first word, one each after.
// - Counter increments only when the step input is sampled low.
// - Global write low writes all four bytes regardless of byte selects.
// - With global write high, a byte writes only when its select and byte write enable are both low.
// - Output enable ignored in first read clock after deselect; data pins undriven.
module sbs_port
   import sbs_pkg::*;
(
   // Clock and reset
   input  wire logic                    clk_in,
   input  wire logic                    rst_in,
   // Address and burst control
   input  wire logic [SBS_ADDR_W-1:0]   addr_in,
   input  wire logic                    proc_addr_strobe_n_in,
   input  wire logic                    ctrl_addr_strobe_n_in,
   input  wire logic                    burst_step_n_in,
   input  wire logic                    burst_order_in,
   // Chip selects
   input  wire logic                    chip_sel_a_n_in,
   input  wire logic                    chip_sel_b_in,
   input  wire logic                    chip_sel_c_n_in,
   // Write control
   input  wire logic [SBS_LANES-1:0]    byte_wr_sel_n_in,
   input  wire logic                    byte_wr_en_n_in,
   input  wire logic                    global_wr_n_in,
   // Asynchronous controls
   input  wire logic                    out_en_n_in,
   input  wire logic                    sleep_in,
   // Data and parity pins
   input  wire logic [SBS_DATA_W-1:0]   dq_in,
   output logic      [SBS_DATA_W-1:0]   dq_out,
   output logic                         dq_oe_out,
   input  wire logic [SBS_LANES-1:0]    parity_io_in,
   output logic      [SBS_LANES-1:0]    parity_io_out,
   output logic                         parity_io_oe_out
);
   ////////////////////////////////////////////////////////////////////////////
   // Input registers
   logic [SBS_ADDR_W-1:0] addr_q;
   logic                  proc_addr_strobe_n_q, ctrl_addr_strobe_n_q, step_q, order_q;
   logic                  cea_q, ceb_q, cec_q, bwe_q, gw_q;
   logic [SBS_LANES-1:0]  bw_q;
   logic [SBS_WORD_W-1:0] wdata_q;
   logic [SBS_WORD_W-1:0] wdata_d;
   logic [SBS_SYNC_W-1:0] sleep_sync_q;
   logic [SBS_SYNC_W-1:0] sleep_sync_d;

   genvar g;
   generate
      for (g = 0; g < SBS_LANES; g++) begin : g_pack
         assign wdata_d[g*SBS_LANE_W +: SBS_LANE_W] =
            {parity_io_in[g], dq_in[g*SBS_BYTE_W +: SBS_BYTE_W]};
      end
   endgenerate

   assign sleep_sync_d = {sleep_sync_q[0], sleep_in};

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         addr_q       <= '0;
         proc_addr_strobe_n_q       <= 1'b1;
         ctrl_addr_strobe_n_q       <= 1'b1;
         step_q       <= 1'b1;
         order_q      <= 1'b0;
         cea_q        <= 1'b1;
         ceb_q        <= 1'b0;
         cec_q        <= 1'b1;
         bw_q         <= SBS_LANE_ALL;
         bwe_q        <= 1'b1;
         gw_q         <= 1'b1;
         wdata_q      <= '0;
         sleep_sync_q <= '0;
      end else begin
         addr_q       <= addr_in;
         proc_addr_strobe_n_q       <= proc_addr_strobe_n_in;
         ctrl_addr_strobe_n_q       <= ctrl_addr_strobe_n_in;
         step_q       <= burst_step_n_in;
         order_q      <= burst_order_in;
         cea_q        <= chip_sel_a_n_in;
         ceb_q        <= chip_sel_b_in;
         cec_q        <= chip_sel_c_n_in;
         bw_q         <= byte_wr_sel_n_in;
         bwe_q        <= byte_wr_en_n_in;
         gw_q         <= global_wr_n_in;
         wdata_q      <= wdata_d;
         sleep_sync_q <= sleep_sync_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Burst counter and access decode
   logic [SBS_ADDR_W-1:0] base_q, base_d, mem_addr;
   logic [SBS_BEAT_W-1:0] beat_q, beat_d, low_w;
   logic                  sel_q, sel_d, drive_q, drive_d;
   logic                  proc_load_w, load_w, ce_ok_w, sel_now_w, wr_w, rd_w;
   logic [SBS_LANES-1:0]  wr_lane;
   logic                  sleep_w;

   assign sleep_w = sleep_sync_q[1];
   // Processor strobe counts only while the first chip select is low
   assign proc_load_w = !proc_addr_strobe_n_q && !cea_q;
   assign load_w      = proc_load_w || !ctrl_addr_strobe_n_q;
   assign ce_ok_w     = !cea_q && ceb_q && !cec_q;
   assign sel_now_w   = (load_w ? ce_ok_w : sel_q) && !sleep_w;

   always_comb begin
      base_d = base_q;
      beat_d = beat_q;
      sel_d  = sel_q;
      if (load_w) begin
         base_d = addr_q;
         beat_d = SBS_BEAT_RST;
         sel_d  = ce_ok_w;
      end else if (sel_q && !step_q) begin
         beat_d = beat_q + SBS_BEAT_ONE;
      end
      if (order_q == SBS_ORDER_INTERLEAVED) begin
         low_w = base_d[SBS_BEAT_W-1:0] ^ beat_d;
      end else begin
         low_w = base_d[SBS_BEAT_W-1:0] + beat_d;
      end
      mem_addr = {base_d[SBS_ADDR_W-1:SBS_BEAT_W], low_w};
   end

   always_comb begin
      wr_w = sel_now_w && !proc_load_w && (!gw_q || (!bwe_q && (bw_q != SBS_LANE_ALL)));
      if (!wr_w) begin
         wr_lane = SBS_LANE_NONE;
      end else if (!gw_q) begin
         wr_lane = SBS_LANE_ALL;
      end else begin
         wr_lane = ~bw_q & {SBS_LANES{!bwe_q}};
      end
      rd_w = sel_now_w && !wr_w;
      // Drive only after the array has answered, so the select cycle stays quiet
      drive_d = rd_w;
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         base_q  <= '0;
         beat_q  <= SBS_BEAT_RST;
         sel_q   <= 1'b0;
         drive_q <= 1'b0;
      end else begin
         base_q  <= base_d;
         beat_q  <= beat_d;
         sel_q   <= sel_d;
         drive_q <= drive_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Array and data pins
   logic [SBS_WORD_W-1:0] rd_data;

   sbs_mem u_mem (
      .clk_in      (clk_in),
      .rst_in      (rst_in),
      .addr_in     (mem_addr),
      .rd_en_in    (rd_w),
      .wr_lane_in  (wr_lane),
      .wr_data_in  (wdata_q),
      .rd_data_out (rd_data)
   );

   generate
      for (g = 0; g < SBS_LANES; g++) begin : g_unpack
         assign dq_out[g*SBS_BYTE_W +: SBS_BYTE_W] = rd_data[g*SBS_LANE_W +: SBS_BYTE_W];
         assign parity_io_out[g] = rd_data[g*SBS_LANE_W + SBS_BYTE_W];
      end
   endgenerate

   // Output enable and sleep gate the drivers directly, without a clock
   assign dq_oe_out        = drive_q && !out_en_n_in && !sleep_in;
   assign parity_io_oe_out = drive_q && !out_en_n_in && !sleep_in;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   property p_load;
      @(posedge clk_in) disable iff (rst_in)
      load_w |=> (beat_q == SBS_BEAT_RST) && (base_q == $past(addr_q));
   endproperty
   a_load: assert property (p_load) else $error("burst start not captured");

   property p_hold;
      @(posedge clk_in) disable iff (rst_in)
      (!load_w && step_q) |=> $stable(beat_q);
   endproperty
   a_hold: assert property (p_hold) else $error("counter moved without step");

   property p_step;
      @(posedge clk_in) disable iff (rst_in)
      (!load_w && sel_q && !step_q) |=> beat_q == $past(beat_q) + SBS_BEAT_ONE;
   endproperty
   a_step: assert property (p_step) else $error("counter did not step");

   property p_inter;
      @(posedge clk_in) disable iff (rst_in)
      (order_q && !load_w) |-> mem_addr[1:0] == (base_q[1:0] ^ beat_d);
   endproperty
   a_inter: assert property (p_inter) else $error("interleaved order wrong");

   property p_linear;
      @(posedge clk_in) disable iff (rst_in)
      (!order_q && !load_w) |-> mem_addr[1:0] == 2'(base_q[1:0] + beat_d);
   endproperty
   a_linear: assert property (p_linear) else $error("linear order wrong");

   property p_gw;
      @(posedge clk_in) disable iff (rst_in)
      (wr_w && !gw_q) |-> wr_lane == SBS_LANE_ALL;
   endproperty
   a_gw: assert property (p_gw) else $error("global write missed a byte");

   property p_bw;
      @(posedge clk_in) disable iff (rst_in)
      (wr_w && gw_q) |-> wr_lane == (~bw_q & {SBS_LANES{!bwe_q}});
   endproperty
   a_bw: assert property (p_bw) else $error("byte write lanes wrong");

   logic ctrl_addr_strobe_n_n_seen;
   assign ctrl_addr_strobe_n_n_seen = ctrl_addr_strobe_n_q;
   property p_burst;
      @(posedge clk_in) disable iff (rst_in)
      (!ctrl_addr_strobe_n_n_seen ##1 rd_w) |=> drive_q;
   endproperty
   a_burst: assert property (p_burst) else $error("first word late");

   property p_quiet;
      @(posedge clk_in) disable iff (rst_in)
      ($past(!sel_q) && load_w) |-> !dq_oe_out;
   endproperty
   a_quiet: assert property (p_quiet) else $error("pins driven on first read clock");

   c_read_burst: cover property (@(posedge clk_in) disable iff (rst_in)
      rd_w ##1 (rd_w && !step_q) [*3]);
   c_write: cover property (@(posedge clk_in) disable iff (rst_in) wr_w && !gw_q);
   c_byte_write: cover property (@(posedge clk_in) disable iff (rst_in)
      wr_w && gw_q && !bwe_q);
endmodule // sbs_port

// *** rtl/sbs_pkg.sv ***
// Shared sizes, reset values and encodings of the burst SRAM port
package sbs_pkg;
   localparam int          SBS_ADDR_W   = 20;
   localparam int          SBS_LANES    = 4;
   localparam int          SBS_LANE_W   = 9;
   localparam int          SBS_BYTE_W   = 8;
   localparam int          SBS_WORD_W   = SBS_LANES * SBS_LANE_W;
   localparam int          SBS_DATA_W   = SBS_LANES * SBS_BYTE_W;
   localparam int          SBS_BEAT_W   = 2;
   localparam int          SBS_SYNC_W   = 2;
   localparam logic [1:0]  SBS_BEAT_RST = 2'h0;
   localparam logic [1:0]  SBS_BEAT_ONE = 2'h1;
   localparam logic [3:0]  SBS_LANE_ALL = 4'hf;
   localparam logic [3:0]  SBS_LANE_NONE = 4'h0;
   localparam logic        SBS_ORDER_INTERLEAVED = 1'b1;
endpackage

// *** rtl/sbs_mem.sv ***
// Word array with per-lane write enables and a registered read port
`timescale 1ns/100ps
module sbs_mem
   import sbs_pkg::*;
(
   // Clock and reset
   input  wire logic                    clk_in,
   input  wire logic                    rst_in,
   // Access
   input  wire logic [SBS_ADDR_W-1:0]   addr_in,
   input  wire logic                    rd_en_in,
   input  wire logic [SBS_LANES-1:0]    wr_lane_in,
   input  wire logic [SBS_WORD_W-1:0]   wr_data_in,
   output logic      [SBS_WORD_W-1:0]   rd_data_out
);
   logic [SBS_WORD_W-1:0] mem_q [0:(1<<SBS_ADDR_W)-1];
   logic [SBS_WORD_W-1:0] rd_q;
   logic [SBS_WORD_W-1:0] rd_d;

   always_comb begin
      rd_d = rd_q;
      if (rd_en_in) begin
         rd_d = mem_q[addr_in];
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rd_q <= '0;
      end else begin
         rd_q <= rd_d;
      end
   end

   // Each lane commits in the same edge as its enable: no write pulse needed
   // One process owns the whole array, so the lanes share a single driver
   always_ff @(posedge clk_in) begin
      for (int i = 0; i < SBS_LANES; i++) begin
         if (wr_lane_in[i]) begin
            mem_q[addr_in][i*SBS_LANE_W +: SBS_LANE_W] <=
               wr_data_in[i*SBS_LANE_W +: SBS_LANE_W];
         end
      end
   end

   assign rd_data_out = rd_q;
endmodule // sbs_mem

// *** verif/sbs_host.sv ***
// Host bus model that drives the burst SRAM port pins
`timescale 1ns/100ps
module sbs_host
   import sbs_pkg::*;
(
   // Clock
   input  wire logic                clk_in,
   // Address and burst control
   output logic [SBS_ADDR_W-1:0]    addr_out,
   output logic                     proc_addr_strobe_n_out,
   output logic                     ctrl_addr_strobe_n_out,
   output logic                     burst_step_n_out,
   output logic                     chip_sel_a_n_out,
   // Write control and data
   output logic                     global_wr_n_out,
   output logic                     byte_wr_en_n_out,
   output logic [SBS_LANES-1:0]     byte_wr_sel_n_out,
   output logic [SBS_DATA_W-1:0]    dq_out,
   output logic [SBS_LANES-1:0]     parity_io_out
);
   initial begin
      {proc_addr_strobe_n_out, ctrl_addr_strobe_n_out, burst_step_n_out} = 3'h7;
      {chip_sel_a_n_out, global_wr_n_out, byte_wr_en_n_out} = 3'h3;
      byte_wr_sel_n_out = 4'hf;
      addr_out = '0;
      dq_out = '0;
      parity_io_out = '0;
   end

   // One bus cycle; pins change just after the edge and stand a full period
   task automatic cyc(input logic ps, cs, st, sa, gw, be, input logic [3:0] bs,
                      input logic [SBS_ADDR_W-1:0] a, input logic [SBS_WORD_W-1:0] w);
      @(posedge clk_in);
      addr_out <= a;
      proc_addr_strobe_n_out <= ps;
      ctrl_addr_strobe_n_out <= cs;
      burst_step_n_out <= st;
      chip_sel_a_n_out <= sa;
      global_wr_n_out <= gw;
      byte_wr_en_n_out <= be;
      byte_wr_sel_n_out <= bs;
      // Idle data lines toggle so stale values never look valid
      for (int i = 0; i < SBS_LANES; i++) begin
         dq_out[8*i+:8] <= (gw & be) ? ~dq_out[8*i+:8] : w[9*i+:8];
         parity_io_out[i] <= (gw & be) ? ~parity_io_out[i] : w[9*i+8];
      end
   endtask
endmodule // sbs_host

// *** verif/sbs_port_tb_top.sv ***
// Self-checking bench for the burst SRAM port
`timescale 1ns/100ps
module sbs_port_tb_top
   import sbs_pkg::*;
;
   localparam logic [SBS_ADDR_W-1:0] BASE = 20'h01230;
   logic                  clk_in, rst_in, ord, oe_n, slp, oe, p_oe;
   logic                  ps, cs, st, sa, gw, be;
   logic [SBS_ADDR_W-1:0] a;
   logic [SBS_LANES-1:0]  bs, par, par_o;
   logic [SBS_DATA_W-1:0] dq, dq_o;
   logic [SBS_WORD_W-1:0] mem [4];
   int                    n_errors = 0;
   int                    check_count = 0;

   sbs_host host (.clk_in(clk_in), .addr_out(a), .proc_addr_strobe_n_out(ps),
      .ctrl_addr_strobe_n_out(cs), .burst_step_n_out(st), .chip_sel_a_n_out(sa),
      .global_wr_n_out(gw), .byte_wr_en_n_out(be), .byte_wr_sel_n_out(bs),
      .dq_out(dq), .parity_io_out(par));

   sbs_port dut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(a),
      .proc_addr_strobe_n_in(ps), .ctrl_addr_strobe_n_in(cs), .burst_step_n_in(st),
      .burst_order_in(ord), .chip_sel_a_n_in(sa), .chip_sel_b_in(1'b1),
      .chip_sel_c_n_in(1'b0), .byte_wr_sel_n_in(bs), .byte_wr_en_n_in(be),
      .global_wr_n_in(gw), .out_en_n_in(oe_n), .sleep_in(slp), .dq_in(dq),
      .dq_out(dq_o), .dq_oe_out(oe), .parity_io_in(par), .parity_io_out(par_o),
      .parity_io_oe_out(p_oe));

   task automatic chk(input logic [SBS_WORD_W-1:0] got, exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   function automatic logic [SBS_WORD_W-1:0] seen();
      logic [SBS_WORD_W-1:0] w;
      for (int i = 0; i < SBS_LANES; i++) w[9*i+:9] = {par_o[i], dq_o[8*i+:8]};
      return w;
   endfunction

   // Burst read from offset s; stp_n is the step pin per cycle, bit 0 at the load
   task automatic rd(input logic o, p, input logic [1:0] s, input logic [5:0] stp_n,
                     input logic blk);
      logic [1:0] n;
      n = 2'h0;
      for (int k = 0; k < 6; k++) begin
         host.cyc(p | (k > 0), !p | (k > 0), stp_n[k], 1'b0, 1'b1, 1'b1, 4'hf, BASE | s, '0);
         ord <= o;
         oe_n <= blk & (k == 3);
         slp <= blk & (k == 4);
         if (k >= 2) begin
            if (k >= 3 && !stp_n[k-2]) n++;
            #1;
            if (blk && (k == 3 || k == 4)) begin
               chk(oe, 1'b0);
               chk(p_oe, 1'b0);
            end else begin
               @(negedge clk_in);
               chk(oe, 1'b1);
               chk(seen(), mem[o ? (s ^ n) : (s + n)]);
            end
         end
      end
   endtask

   // Linear write burst of nb beats from offset s
   task automatic wr(input logic [1:0] s, input logic g, e, input logic [3:0] bs, input int nb);
      logic [SBS_WORD_W-1:0] w;
      for (int j = 0; j < nb; j++) begin
         w = {4{s, 7'(j * 19 + 3)}};
         host.cyc(1'b1, j > 0, j == 0, 1'b0, g, e, bs, BASE | s, w);
         ord <= 1'b0;
         for (int i = 0; i < SBS_LANES; i++)
            if (!g || (!e && !bs[i])) mem[2'(s + j)][9*i+:9] = w[9*i+:9];
      end
      host.cyc(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 4'hf, BASE, '0);
   endtask

   // Deselected load carrying a global write must not touch the array
   task automatic desel();
      host.cyc(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 4'hf, BASE, '0);
      repeat (3) host.cyc(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf, BASE, '0);
      #1;
      chk(oe, 1'b0);
   endtask

   task automatic close_out();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end

   initial begin
      rst_in = 1'b1;
      ord = 1'b0;
      oe_n = 1'b0;
      slp = 1'b0;
      repeat (3) @(posedge clk_in);
      rst_in <= 1'b0;
      wr(2'h1, 1'b0, 1'b1, 4'hf, 4);
      rd(1'b0, 1'b0, 2'h1, 6'b110001, 1'b0);
      rd(1'b1, 1'b1, 2'h2, 6'b110001, 1'b1);
      wr(2'h2, 1'b1, 1'b0, 4'b1010, 1);
      wr(2'h3, 1'b0, 1'b1, 4'hf, 1);
      wr(2'h0, 1'b1, 1'b1, 4'h0, 1);
      desel();
      rd(1'b0, 1'b0, 2'h0, 6'b110011, 1'b0);
      rd(1'b1, 1'b1, 2'h3, 6'b110001, 1'b0);
      close_out();
   end
endmodule // sbs_port_tb_top
